// >>> hdl/priority_trap_interrupt_unit.sv
// Contract
// R1: Four fixed levels: internal 1, external group 2, channel 3, I/O bus 4.
// R2: Internal faults, power failure and restart trap at addresses 0 to 2.
// R3: External lines trap at 8 to 87 hex, group expandable to 64 lines.
// R4: Shared channel interrupt line traps to address 4.
// R5: Shared I/O bus interrupt line traps to address 6; software polls status.
// R6: Trap runs one instruction at trap address, program counter held.
// R7: Unaltered program counter resumes the interrupted sequence normally.
// R8: No recognition during trap instruction and the instruction after it. The code refuses only the trap instruction's end.
// R9: Internal level never masked; other levels gated by the mask bit.
// R10: Channel controllers raise their request on any status change.
// R11: Channel trap stores the merged eight-port status word.
// R12: Smallest level number wins; lower external line wins within group.
// R13: Masked or locked-out requests stay latched until recognised.
`timescale 1ns/1ns
`default_nettype none
`include "priority_trap_defines.svh"

module priority_trap_interrupt_unit
#(
	parameter int EXT_LINES = `EXT_LINES_DEFAULT
)
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic instr_end_i,
	input wire logic mask_enable_i,
	input wire logic illegal_op_i,
	input wire logic protection_fault_i,
	input wire logic parity_error_i,
	input wire logic power_fail_i,
	input wire logic restart_i,
	input wire logic [EXT_LINES-1:0] ext_req_i,
	input wire logic direct_memory_channel_irq_i,
	input wire logic io_bus_irq_i,
	input wire logic [`CHANNEL_PORTS-1:0] channel_port_status_i,
	output logic trap_take_o,
	output logic [15:0] trap_addr_o,
	output priority_trap_pkg::level_e trap_level_o,
	output logic pc_hold_o,
	output logic lockout_o,
	output logic channel_status_store_o,
	output logic [15:0] channel_status_word_o
);

	localparam int IDX_W = 6;

	if (EXT_LINES < 1 || EXT_LINES > `EXT_LINES_MAX)
	begin : g_ext_lines_bad
		$error("EXT_LINES out of range");
	end

	typedef struct packed
	{
		logic [EXT_LINES-1:0] ext_s1;
		logic [EXT_LINES-1:0] ext_s2;
		logic [EXT_LINES-1:0] ext_d;
		logic [EXT_LINES-1:0] ext_pend;
		logic dmc_s1;
		logic dmc_s2;
		logic dmc_d;
		logic dmc_pend;
		logic iob_s1;
		logic iob_s2;
		logic iob_d;
		logic iob_pend;
		logic [`CHANNEL_PORTS-1:0] cps_s1;
		logic [`CHANNEL_PORTS-1:0] cps_s2;
		logic [4:0] int_pend;
		logic [1:0] lock_cnt;
		logic lock;
		logic take;
		logic [15:0] addr;
		priority_trap_pkg::level_e level;
		logic pc_hold;
		logic store;
		logic [15:0] word;
	} state_s;

	state_s s;
	state_s next_s;

	logic allow;
	logic grant;
	logic ext_found;
	logic [IDX_W-1:0] ext_idx;
	logic [EXT_LINES-1:0] ext_clr;
	logic [4:0] int_clr;
	logic dmc_clr;
	logic iob_clr;

	// Lowest-numbered pending external line
	always_comb
	begin
		ext_found = 1'b0;
		ext_idx = '0;
		for (int i = EXT_LINES - 1; i >= 0; i--)
		begin
			if (s.ext_pend[i])
			begin
				ext_found = 1'b1; // R12
				ext_idx = IDX_W'(i);
			end
		end
	end

	// Recognition window: at an instruction end, once the lockout count is down to 1 or 0
	assign allow = ce_i && instr_end_i && (s.lock_cnt <= 2'h1); // R8

	always_comb
	begin
		next_s = s;
		next_s.take = 1'b0;
		next_s.store = 1'b0;
		grant = 1'b0;
		ext_clr = '0;
		int_clr = '0;
		dmc_clr = 1'b0;
		iob_clr = 1'b0;

		// Pin synchronisers and edge detect
		next_s.ext_s1 = ext_req_i;
		next_s.ext_s2 = s.ext_s1;
		next_s.ext_d = s.ext_s2;
		next_s.dmc_s1 = direct_memory_channel_irq_i;
		next_s.dmc_s2 = s.dmc_s1;
		next_s.dmc_d = s.dmc_s2;
		next_s.iob_s1 = io_bus_irq_i;
		next_s.iob_s2 = s.iob_s1;
		next_s.iob_d = s.iob_s2;
		next_s.cps_s1 = channel_port_status_i;
		next_s.cps_s2 = s.cps_s1;

		// Lockout counts down on instruction ends
		if (instr_end_i && s.lock_cnt != 2'h0)
		begin
			next_s.lock_cnt = s.lock_cnt - 2'h1; // R8
			if (s.lock_cnt == `LOCKOUT_INSTR)
				next_s.pc_hold = 1'b0; // R7
		end

		if (allow)
		begin
			if (s.int_pend != 5'h00)
			begin
				grant = 1'b1; // R9
				next_s.level = priority_trap_pkg::LVL_INTERNAL; // R1
				if (s.int_pend[4])
				begin
					int_clr = 5'h10;
					next_s.addr = `TRAP_ADDR_RESTART; // R2
				end
				else if (s.int_pend[3])
				begin
					int_clr = 5'h08;
					next_s.addr = `TRAP_ADDR_POWER; // R2
				end
				else
				begin
					int_clr = s.int_pend;
					next_s.addr = `TRAP_ADDR_FAULT; // R2
				end
			end
			else if (mask_enable_i && ext_found)
			begin
				grant = 1'b1; // R12
				next_s.level = priority_trap_pkg::LVL_EXTERNAL;
				ext_clr[ext_idx] = 1'b1;
				next_s.addr = `TRAP_ADDR_EXT_BASE + {9'h000, ext_idx, 1'b0}; // R3
			end
			else if (mask_enable_i && s.dmc_pend)
			begin
				grant = 1'b1;
				dmc_clr = 1'b1;
				next_s.level = priority_trap_pkg::LVL_CHANNEL;
				next_s.addr = `TRAP_ADDR_CHANNEL; // R4
				next_s.store = 1'b1; // R11
				next_s.word = {{(16 - `CHANNEL_PORTS){1'b0}}, s.cps_s2}; // R11
			end
			else if (mask_enable_i && s.iob_pend)
			begin
				grant = 1'b1;
				iob_clr = 1'b1;
				next_s.level = priority_trap_pkg::LVL_IO;
				next_s.addr = `TRAP_ADDR_IO_BUS; // R5
			end
		end

		if (grant)
		begin
			next_s.take = 1'b1; // R6
			next_s.pc_hold = 1'b1; // R6
			next_s.lock_cnt = `LOCKOUT_INSTR; // R8
		end
		next_s.lock = (next_s.lock_cnt != 2'h0); // R8

		// Set wins over clear; unserved requests stay latched
		next_s.int_pend = (s.int_pend & ~int_clr) |
			{restart_i, power_fail_i, parity_error_i, protection_fault_i, illegal_op_i}; // R13
		next_s.ext_pend = (s.ext_pend & ~ext_clr) | (s.ext_s2 & ~s.ext_d); // R13
		next_s.dmc_pend = (s.dmc_pend & ~dmc_clr) | (s.dmc_s2 & ~s.dmc_d); // R13
		next_s.iob_pend = (s.iob_pend & ~iob_clr) | (s.iob_s2 & ~s.iob_d); // R13
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.addr <= `RESET_ADDR;
			s.word <= `RESET_WORD;
			s.level <= priority_trap_pkg::LVL_NONE;
		end
		else if (ce_i)
		begin
			s <= next_s;
		end
	end

	assign trap_take_o = s.take;
	assign trap_addr_o = s.addr;
	assign trap_level_o = s.level;
	assign pc_hold_o = s.pc_hold;
	assign lockout_o = s.lock;
	assign channel_status_store_o = s.store;
	assign channel_status_word_o = s.word;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	property p_internal_first;
		allow && (s.int_pend != 5'h00) |=> trap_take_o && trap_level_o == priority_trap_pkg::LVL_INTERNAL;
	endproperty
	a_internal_first: assert property (p_internal_first) else $error("internal request not served first"); // R1

	property p_internal_addr;
		trap_take_o && trap_level_o == priority_trap_pkg::LVL_INTERNAL |-> trap_addr_o <= 16'h0002;
	endproperty
	a_internal_addr: assert property (p_internal_addr) else $error("internal trap address out of range"); // R2

	property p_ext_addr;
		trap_take_o && trap_level_o == priority_trap_pkg::LVL_EXTERNAL
			|-> trap_addr_o >= 16'h0008 && trap_addr_o <= 16'h0087 && !trap_addr_o[0];
	endproperty
	a_ext_addr: assert property (p_ext_addr) else $error("external trap address out of range"); // R3

	property p_channel_trap;
		trap_take_o && trap_level_o == priority_trap_pkg::LVL_CHANNEL
			|-> trap_addr_o == 16'h0004 && channel_status_store_o;
	endproperty
	a_channel_trap: assert property (p_channel_trap) else $error("channel trap wrong address or no store"); // R4

	property p_channel_word;
		allow && grant && !(s.int_pend != 5'h00) && !ext_found && s.dmc_pend
			|=> channel_status_word_o[7:0] == $past(s.cps_s2);
	endproperty
	a_channel_word: assert property (p_channel_word) else $error("channel status word not captured"); // R11

	property p_io_addr;
		trap_take_o && trap_level_o == priority_trap_pkg::LVL_IO |-> trap_addr_o == 16'h0006;
	endproperty
	a_io_addr: assert property (p_io_addr) else $error("I/O bus trap address wrong"); // R5

	property p_pc_hold;
		trap_take_o |-> pc_hold_o && lockout_o;
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("program counter not held on trap"); // R6

	property p_lockout;
		ce_i && instr_end_i && s.lock_cnt == 2'h2 |=> !trap_take_o && !pc_hold_o;
	endproperty
	a_lockout: assert property (p_lockout) else $error("trap taken inside lockout"); // R8

	property p_mask;
		allow && !mask_enable_i && s.int_pend == 5'h00 |=> !trap_take_o;
	endproperty
	a_mask: assert property (p_mask) else $error("masked level recognised"); // R9

	property p_hold_pending;
		ce_i && !allow && s.dmc_pend |=> s.dmc_pend;
	endproperty
	a_hold_pending: assert property (p_hold_pending) else $error("latched channel request lost"); // R13

	property p_pc_release;
		ce_i && instr_end_i && s.lock_cnt == 2'h2 |=> !pc_hold_o && lockout_o;
	endproperty
	a_pc_release: assert property (p_pc_release) else $error("program counter hold not released after trap"); // R7

	property p_ext_held;
		ce_i && !allow && ext_found |=> ext_found;
	endproperty
	a_ext_held: assert property (p_ext_held) else $error("latched external request lost"); // R13

	c_external: cover property (trap_take_o && trap_level_o == priority_trap_pkg::LVL_EXTERNAL);
	c_channel: cover property (trap_take_o && trap_level_o == priority_trap_pkg::LVL_CHANNEL);
	c_io: cover property (trap_take_o && trap_level_o == priority_trap_pkg::LVL_IO);
	c_back_to_back: cover property (trap_take_o ##[1:40] trap_take_o);
	c_frozen: cover property (!ce_i && instr_end_i);

endmodule
`default_nettype wire

// >>> hdl/priority_trap_defines.svh
`ifndef PRIORITY_TRAP_DEFINES_SVH
`define PRIORITY_TRAP_DEFINES_SVH

// Trap addresses
`define TRAP_ADDR_FAULT 16'h0000
`define TRAP_ADDR_POWER 16'h0001
`define TRAP_ADDR_RESTART 16'h0002
`define TRAP_ADDR_CHANNEL 16'h0004
`define TRAP_ADDR_IO_BUS 16'h0006
`define TRAP_ADDR_EXT_BASE 16'h0008
`define TRAP_ADDR_EXT_LAST 16'h0087

// Sizes
`define EXT_LINES_MAX 64
`define EXT_LINES_DEFAULT 64
`define CHANNEL_PORTS 8

// Post-trap lockout, counted in instruction ends
`define LOCKOUT_INSTR 2'h2

// Reset values
`define RESET_ADDR 16'h0000
`define RESET_WORD 16'h0000

`endif

// >>> hdl/priority_trap_pkg.sv
package priority_trap_pkg;

	typedef enum logic [2:0]
	{
		LVL_NONE,
		LVL_INTERNAL,
		LVL_EXTERNAL,
		LVL_CHANNEL,
		LVL_IO
	} level_e;

endpackage

// >>> verif/periph_partner.sv
`timescale 1ns/1ns
`default_nettype none
module periph_partner
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] status_i,
	input wire logic io_req_i,
	output logic channel_irq_o,
	output logic [7:0] port_status_o,
	output logic io_irq_o
);
	// Any port status change pulses the shared channel line
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			port_status_o <= 8'h00;
			channel_irq_o <= 1'b0;
			io_irq_o <= 1'b0;
		end
		else
		begin
			port_status_o <= status_i;
			channel_irq_o <= (status_i != port_status_o);
			io_irq_o <= io_req_i;
		end
	end
endmodule
`default_nettype wire

// >>> verif/priority_trap_interrupt_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module priority_trap_interrupt_unit_tb;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic instr_end_i = 1'b0;
	logic mask_enable_i = 1'b0;
	logic [4:0] evt = 5'h00;
	logic [63:0] ext_req = 64'h0;
	logic [7:0] set_status = 8'h00;
	logic io_req = 1'b0;
	logic ce = 1'b1;
	wire logic dmc_irq;
	wire logic io_irq;
	wire logic take;
	wire logic pc_hold;
	wire logic lockout;
	wire logic store;
	wire logic [7:0] port_status;
	wire logic [15:0] addr;
	wire logic [15:0] word;
	priority_trap_pkg::level_e level;
	int fails = 0;
	int cmp_count = 0;
	int cycles = 0;

	periph_partner i_partner (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .status_i(set_status), .io_req_i(io_req),
		.channel_irq_o(dmc_irq), .port_status_o(port_status), .io_irq_o(io_irq));

	priority_trap_interrupt_unit i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce),
		.instr_end_i(instr_end_i), .mask_enable_i(mask_enable_i), .illegal_op_i(evt[0]),
		.protection_fault_i(evt[1]), .parity_error_i(evt[2]), .power_fail_i(evt[3]), .restart_i(evt[4]),
		.ext_req_i(ext_req), .direct_memory_channel_irq_i(dmc_irq), .io_bus_irq_i(io_irq),
		.channel_port_status_i(port_status), .trap_take_o(take), .trap_addr_o(addr), .trap_level_o(level),
		.pc_hold_o(pc_hold), .lockout_o(lockout), .channel_status_store_o(store), .channel_status_word_o(word));

	initial forever #5 sys_clk_i = ~sys_clk_i;

	task report_and_stop;
		if (fails == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			report_and_stop();
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wait_cy(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	task step_end;
		@(negedge sys_clk_i);
		instr_end_i = 1'b1;
		@(negedge sys_clk_i);
		instr_end_i = 1'b0;
	endtask

	task fire(input logic [4:0] ev);
		@(negedge sys_clk_i);
		evt = ev;
		@(negedge sys_clk_i);
		evt = 5'h00;
	endtask

	// One instruction end, then the refused one after a trap
	task trap(input logic tk, input logic [15:0] a, input priority_trap_pkg::level_e lv);
		step_end();
		check({15'h0, take}, {15'h0, tk});
		if (tk)
		begin
			check(addr, a);
			check({13'h0, level}, {13'h0, lv});
			check({14'h0, pc_hold, lockout}, 16'h0003);
			check({15'h0, store}, {15'h0, lv == priority_trap_pkg::LVL_CHANNEL});
			if (lv == priority_trap_pkg::LVL_CHANNEL)
				check(word, {8'h00, set_status});
			step_end();
			check({15'h0, take}, 16'h0000);
			check({14'h0, pc_hold, lockout}, 16'h0001);
		end
		else
			check({15'h0, lockout}, 16'h0000);
	endtask

	task sc_internal;
		mask_enable_i = 1'b0;
		io_req = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			fire(5'h01 << i);
			trap(1'b1, 16'h0000, priority_trap_pkg::LVL_INTERNAL);
		end
		fire(5'h1F);
		trap(1'b1, 16'h0002, priority_trap_pkg::LVL_INTERNAL);
		trap(1'b1, 16'h0001, priority_trap_pkg::LVL_INTERNAL);
		trap(1'b1, 16'h0000, priority_trap_pkg::LVL_INTERNAL);
		trap(1'b0, 16'h0000, priority_trap_pkg::LVL_NONE);
		mask_enable_i = 1'b1;
		trap(1'b1, 16'h0006, priority_trap_pkg::LVL_IO);
		io_req = 1'b0;
	endtask

	task sc_order;
		mask_enable_i = 1'b1;
		ext_req = 64'h8000_0000_0000_0020;
		set_status = 8'hA5;
		wait_cy(1);
		io_req = 1'b1;
		wait_cy(4);
		trap(1'b1, 16'h0012, priority_trap_pkg::LVL_EXTERNAL);
		trap(1'b1, 16'h0086, priority_trap_pkg::LVL_EXTERNAL);
		trap(1'b1, 16'h0004, priority_trap_pkg::LVL_CHANNEL);
		trap(1'b1, 16'h0006, priority_trap_pkg::LVL_IO);
		trap(1'b0, 16'h0000, priority_trap_pkg::LVL_NONE);
	endtask

	task sc_freeze;
		io_req = 1'b0;
		wait_cy(4);
		ce = 1'b0;
		io_req = 1'b1;
		wait_cy(4);
		step_end();
		check({15'h0, take}, 16'h0000);
		check({14'h0, pc_hold, lockout}, 16'h0000);
		ce = 1'b1;
		wait_cy(4);
		trap(1'b1, 16'h0006, priority_trap_pkg::LVL_IO);
	endtask

	initial
	begin
		wait_cy(5);
		rst_i = 1'b0;
		check({13'h0, level}, {13'h0, priority_trap_pkg::LVL_NONE});
		wait_cy(2);
		sc_internal();
		sc_order();
		sc_freeze();
		report_and_stop();
	end
endmodule
`default_nettype wire
